// File: inc/frbs_pkg.sv
package frbs_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] OFF_CFG   = 12'h000;
   localparam logic [11:0] OFF_STAT  = 12'h004;
   localparam logic [11:0] OFF_MADDR = 12'h008;
   localparam logic [11:0] OFF_MDATA = 12'h00C;
   localparam logic [11:0] OFF_SWORD = 12'h010;

   // ----------------------------------------
   // Configuration fields and reset values
   // ----------------------------------------
   localparam int          CFG_RSEL_BIT = 15;
   localparam int          CFG_WRAP_BIT = 3;
   localparam int          CFG_LEN_LSB  = 0;
   localparam int          CFG_SRC_LSB  = 16;
   localparam logic [31:0] CFG_MASK     = 32'h0003800F;
   localparam logic [31:0] CFG_RST      = 32'h0000800F;
   localparam logic [15:0] SWORD_RST    = 16'h0080;

   // ----------------------------------------
   // Burst length codes
   // ----------------------------------------
   localparam logic [2:0] LEN_4  = 3'h1;
   localparam logic [2:0] LEN_8  = 3'h2;
   localparam logic [2:0] LEN_16 = 3'h3;
   localparam logic [2:0] LEN_C  = 3'h7;

   // ----------------------------------------
   // Identity words, values are arbitrary
   // ----------------------------------------
   localparam logic [15:0] IDENT_WORD = 16'h5A5A;
   localparam logic [15:0] QUERY_WORD = 16'h1234;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int          CLK_NS   = 25;
   localparam int          STBY_NS  = 150;
   localparam int          RAND_NS  = 100;
   localparam int          PAGE_NS  = 25;
   localparam logic [3:0]  STBY_CYC = 4'((STBY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  RAND_CYC = 4'((RAND_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  PAGE_CYC = 4'((PAGE_NS + CLK_NS - 1) / CLK_NS);

   typedef enum {SRC_ARRAY, SRC_STATUS, SRC_QUERY, SRC_IDENT} frbs_src_e;
   typedef enum {ST_IDLE, ST_RUN} frbs_st_e;

endpackage

// File: inc/frbs_link_if.sv
`timescale 1ns/1ps
interface frbs_link_if #(parameter int AW = 8);
   logic          sync_mode;
   logic          wrap_sel;
   logic [2:0]    blen;
   logic [AW-1:0] word_addr;
   logic          word_valid;
   logic          wait_act;

   modport gen (input sync_mode, wrap_sel, blen, output word_addr, word_valid, wait_act);
   modport top (output sync_mode, wrap_sel, blen, input word_addr, word_valid, wait_act);
endinterface

// File: hdl/frbs_burst_gen.sv
`timescale 1ns/1ps
module frbs_burst_gen #(
   parameter int AW = 8
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   // Link pins
   input  wire logic [AW-1:0] i_addr,
   input  wire logic          i_adv_n,
   input  wire logic          i_ce_n,
   // Sequencer
   frbs_link_if.gen           lk
);
   import frbs_pkg::*;

   frbs_st_e      st, next_st;
   logic [AW-1:0] cur, next_cur, word, next_word, amask;
   logic [1:0]    off, next_off, pend, next_pend;
   logic [4:0]    left, next_left;
   logic          crossed, next_crossed, valid, next_valid, wt, next_wt;
   logic          cont, wrapm;
   logic [3:0]    mask;

   // ----------------------------------------
   // Word order
   // ----------------------------------------
   always_comb
   begin
      cont         = (lk.blen != LEN_4) && (lk.blen != LEN_8) && (lk.blen != LEN_16);
      wrapm        = !lk.wrap_sel && !cont;
      case (lk.blen)
         LEN_4:   mask = 4'h3;
         LEN_8:   mask = 4'h7;
         default: mask = 4'hF;
      endcase
      amask        = {{(AW-4){1'b0}}, mask};
      next_st      = st;
      next_cur     = cur;
      next_word    = word;
      next_off     = off;
      next_pend    = pend;
      next_left    = left;
      next_crossed = crossed;
      next_valid   = 1'b0;
      next_wt      = 1'b0;
      if (i_ce_n || !lk.sync_mode)
         next_st = ST_IDLE;
      else if (!i_adv_n)
      begin
         next_cur     = i_addr;
         next_off     = i_addr[1:0];
         next_left    = {1'b0, mask} + 5'h01;
         next_pend    = 2'h0;
         next_crossed = 1'b0;
         next_st      = ST_RUN;
      end
      else
      begin
         case (st)
            ST_RUN:
            begin
               if (pend != 2'h0)
               begin
                  next_pend = pend - 2'h1;
                  next_wt   = 1'b1;
               end
               else if (!cont && left == 5'h00)
                  next_st = ST_IDLE;
               else
               begin
                  next_valid = 1'b1;
                  next_word  = cur;
                  if (wrapm)
                     next_cur = (cur & ~amask) | ((cur + AW'(1)) & amask);
                  else
                     next_cur = cur + AW'(1);
                  if (!cont)
                     next_left = left - 5'h01;
                  if (!wrapm && cur[3:0] == 4'hF && !crossed)
                  begin
                     next_pend    = off;
                     next_crossed = 1'b1;
                  end
               end
            end
            default: next_st = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         st      <= ST_IDLE;
         cur     <= '0;
         word    <= '0;
         off     <= 2'h0;
         pend    <= 2'h0;
         left    <= 5'h00;
         crossed <= 1'b0;
         valid   <= 1'b0;
         wt      <= 1'b0;
      end
      else
      begin
         st      <= next_st;
         cur     <= next_cur;
         word    <= next_word;
         off     <= next_off;
         pend    <= next_pend;
         left    <= next_left;
         crossed <= next_crossed;
         valid   <= next_valid;
         wt      <= next_wt;
      end
   end

   assign lk.word_addr  = word;
   assign lk.word_valid = valid;
   assign lk.wait_act   = wt;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence wait3_s;
      wt [*3] ##1 !wt;
   endsequence

   wrap_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (valid && $past(valid) && wrapm && $stable(lk.blen) && $past(wrapm))
      |-> ((word & ~amask) == ($past(word) & ~amask)))
      else $error("wrap burst left its block");

   wait_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
      ($rose(wt) && off == 2'h3 && !i_ce_n && i_adv_n && lk.sync_mode) |-> wait3_s)
      else $error("wrong number of wait cycles");

   aligned_nowait_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(wt) |-> (off != 2'h0))
      else $error("wait asserted on aligned start");

   start_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_ce_n && !i_adv_n && lk.sync_mode) |=> (cur == $past(i_addr) && st == ST_RUN))
      else $error("burst start address not loaded");

   burst_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (st == ST_RUN && !cont) |-> (left <= 5'h10))
      else $error("burst word count out of range");

endmodule

// File: hdl/frbs_top.sv
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Configuration selects asynchronous or synchronous reads.
// - Read mode applies to every bank.
// - Async read ignores clock, returns selected source.
// - Async reads: random access or page access.
// - Async page holds four words, low address bits.
// - New page slow, same page fast.
// - Idle bus in async mode enters automatic standby.
// - Standby keeps driving last data.
// - Wait stays deasserted in async mode.
// - Burst order wraps or runs linearly.
// - Wrap select confines or frees fixed-length burst.
// - Burst length codes four, eight, sixteen, continuous.
// - Unaligned linear burst waits once, offset cycles, on crossing a 16-word boundary.
// - Aligned start needs no wait.
module frbs_top #(
   parameter int AW = frbs_pkg::ADDR_W
) (
   // System clock and reset
   input  wire logic                        I_SYS_CLK,
   input  wire logic                        I_RST,
   // APB slave
   input  wire logic                        I_PSEL,
   input  wire logic                        I_PENABLE,
   input  wire logic                        I_PWRITE,
   input  wire logic [11:0]                 I_PADDR,
   input  wire logic [31:0]                 I_PWDATA,
   output logic      [31:0]                 O_PRDATA,
   output logic                             O_PREADY,
   output logic                             O_PSLVERR,
   // Link clock and pins
   input  wire logic                        I_LINK_CLK,
   input  wire logic [AW-1:0]               I_ADDR,
   input  wire logic                        I_ADV_N,
   input  wire logic                        I_CE_N,
   input  wire logic                        I_OE_N,
   // Asynchronous read data
   output logic      [frbs_pkg::DATA_W-1:0] O_DQ,
   output logic                             O_DQ_OE,
   output logic                             O_STANDBY,
   // Synchronous burst data
   output logic      [frbs_pkg::DATA_W-1:0] O_BURST_DQ,
   output logic                             O_BURST_VALID,
   output logic                             O_WAIT
);
   import frbs_pkg::*;

   localparam int PW = AW + 3;

   logic [DATA_W-1:0] mem [2**AW];
   logic [DATA_W-1:0] page_buf [4], next_page_buf [4];

   logic [31:0]       cfg, next_cfg, next_prdata;
   logic [AW-1:0]     maddr, next_maddr;
   logic [15:0]       sword, next_sword;
   logic              next_pready, next_pslverr, apb_wr, mem_wr;

   logic [PW-1:0]     pin_m, pin_s, pin_q;
   logic [AW-1:0]     s_addr, lat, next_lat;
   logic              s_adv_n, s_ce_n, s_oe_n, pin_chg, async_en;
   logic [AW-3:0]     tag, next_tag;
   logic              page_ok, next_page_ok, busy, next_busy;
   logic              acc_start, acc_miss;
   logic [3:0]        acc_cnt, next_acc_cnt, idle_cnt, next_idle_cnt;
   logic [DATA_W-1:0] next_dq, word;
   logic              next_dq_oe, next_standby;
   frbs_src_e         src;

   logic              lrst_m, lrst;
   logic [4:0]        lcfg_m, lcfg;
   logic [DATA_W-1:0] next_bdq;

   frbs_link_if #(.AW(AW)) lk ();

   // ----------------------------------------
   // APB registers
   // ----------------------------------------
   assign apb_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
   assign mem_wr = apb_wr && I_PADDR == OFF_MDATA;

   always_comb
   begin
      next_cfg     = cfg;
      next_maddr   = maddr;
      next_sword   = sword;
      next_pready  = 1'b0;
      next_prdata  = O_PRDATA;
      next_pslverr = 1'b0;
      if (I_PSEL && I_PENABLE && !O_PREADY)
      begin
         next_pready = 1'b1;
         next_prdata = 32'h00000000;
         case (I_PADDR)
            OFF_CFG:   next_prdata = cfg;
            OFF_STAT:  next_prdata = {28'h0000000, page_ok, busy, async_en, O_STANDBY};
            OFF_MADDR: next_prdata = {{(32-AW){1'b0}}, maddr};
            OFF_MDATA: next_prdata = {16'h0000, mem[maddr]};
            OFF_SWORD: next_prdata = {16'h0000, sword};
            default:   next_pslverr = 1'b1;
         endcase
      end
      if (apb_wr)
      begin
         case (I_PADDR)
            OFF_CFG:   next_cfg   = I_PWDATA & CFG_MASK;
            OFF_MADDR: next_maddr = I_PWDATA[AW-1:0];
            OFF_MDATA: next_maddr = maddr + AW'(1);
            OFF_SWORD: next_sword = I_PWDATA[15:0];
            default:   next_sword = sword;
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RST)
      begin
         cfg       <= CFG_RST;
         maddr     <= '0;
         sword     <= SWORD_RST;
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h00000000;
         O_PSLVERR <= 1'b0;
      end
      else
      begin
         cfg       <= next_cfg;
         maddr     <= next_maddr;
         sword     <= next_sword;
         O_PREADY  <= next_pready;
         O_PRDATA  <= next_prdata;
         O_PSLVERR <= next_pslverr;
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (mem_wr)
         mem[maddr] <= I_PWDATA[DATA_W-1:0];
   end

   // ----------------------------------------
   // Asynchronous read path
   // ----------------------------------------
   assign s_addr   = pin_s[AW-1:0];
   assign s_oe_n   = pin_s[AW];
   assign s_ce_n   = pin_s[AW+1];
   assign s_adv_n  = pin_s[AW+2];
   assign pin_chg  = pin_s != pin_q;
   assign async_en = cfg[CFG_RSEL_BIT];
   assign src      = frbs_src_e'(cfg[CFG_SRC_LSB+1:CFG_SRC_LSB]);

   always_comb
   begin
      next_lat      = s_adv_n ? lat : s_addr;
      acc_start     = async_en && !s_ce_n && (next_lat != lat || pin_q[AW+1]);
      acc_miss      = !page_ok || next_lat[AW-1:2] != tag;
      next_tag      = tag;
      next_page_ok  = page_ok && !mem_wr;
      next_busy     = busy;
      next_acc_cnt  = acc_cnt;
      next_page_buf = page_buf;
      next_dq       = O_DQ;
      case (src)
         SRC_ARRAY:  word = page_ok ? page_buf[lat[1:0]] : mem[lat];
         SRC_STATUS: word = sword;
         SRC_QUERY:  word = QUERY_WORD;
         default:    word = IDENT_WORD;
      endcase
      if (acc_start)
      begin
         next_busy    = 1'b1;
         next_acc_cnt = acc_miss ? RAND_CYC : PAGE_CYC;
         if (acc_miss)
         begin
            next_tag     = next_lat[AW-1:2];
            next_page_ok = 1'b0;
         end
      end
      else if (busy)
      begin
         next_acc_cnt = acc_cnt - 4'h1;
         if (acc_cnt == 4'h1)
         begin
            next_busy = 1'b0;
            next_dq   = word;
            if (!page_ok)
            begin
               for (int i = 0; i < 4; i++)
                  next_page_buf[i] = mem[{tag, 2'(i)}];
               next_page_ok = !mem_wr;
            end
         end
      end
      next_dq_oe = async_en && !s_ce_n && !s_oe_n;
      if (pin_chg || !async_en)
      begin
         next_idle_cnt = 4'h0;
         next_standby  = 1'b0;
      end
      else
      begin
         next_idle_cnt = (idle_cnt == STBY_CYC) ? idle_cnt : idle_cnt + 4'h1;
         next_standby  = next_idle_cnt == STBY_CYC;
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RST)
      begin
         pin_m     <= {3'h7, {AW{1'b0}}};
         pin_s     <= {3'h7, {AW{1'b0}}};
         pin_q     <= {3'h7, {AW{1'b0}}};
         lat       <= '0;
         tag       <= '0;
         page_ok   <= 1'b0;
         busy      <= 1'b0;
         acc_cnt   <= 4'h0;
         idle_cnt  <= 4'h0;
         O_DQ      <= '0;
         O_DQ_OE   <= 1'b0;
         O_STANDBY <= 1'b0;
         for (int i = 0; i < 4; i++)
            page_buf[i] <= '0;
      end
      else
      begin
         pin_m     <= {I_ADV_N, I_CE_N, I_OE_N, I_ADDR};
         pin_s     <= pin_m;
         pin_q     <= pin_s;
         lat       <= next_lat;
         tag       <= next_tag;
         page_ok   <= next_page_ok;
         busy      <= next_busy;
         acc_cnt   <= next_acc_cnt;
         idle_cnt  <= next_idle_cnt;
         O_DQ      <= next_dq;
         O_DQ_OE   <= next_dq_oe;
         O_STANDBY <= next_standby;
         page_buf  <= next_page_buf;
      end
   end

   // ----------------------------------------
   // Link domain
   // ----------------------------------------
   assign lk.sync_mode = !lcfg[4];
   assign lk.wrap_sel  = lcfg[3];
   assign lk.blen      = lcfg[2:0];

   always_comb
   begin
      next_bdq = lk.word_valid ? mem[lk.word_addr] : O_BURST_DQ;
   end

   always_ff @(posedge I_LINK_CLK)
   begin
      lrst_m <= I_RST;
      lrst   <= lrst_m;
   end

   always_ff @(posedge I_LINK_CLK)
   begin
      if (lrst)
      begin
         lcfg_m        <= 5'h1F;
         lcfg          <= 5'h1F;
         O_BURST_DQ    <= '0;
         O_BURST_VALID <= 1'b0;
         O_WAIT        <= 1'b0;
      end
      else
      begin
         lcfg_m        <= {cfg[CFG_RSEL_BIT], cfg[CFG_WRAP_BIT], cfg[CFG_LEN_LSB+2:CFG_LEN_LSB]};
         lcfg          <= lcfg_m;
         O_BURST_DQ    <= next_bdq;
         O_BURST_VALID <= lk.word_valid;
         O_WAIT        <= lk.wait_act;
      end
   end

   frbs_burst_gen #(.AW(AW)) u_gen (
      .i_clk   (I_LINK_CLK),
      .i_rst   (lrst),
      .i_addr  (I_ADDR),
      .i_adv_n (I_ADV_N),
      .i_ce_n  (I_CE_N),
      .lk      (lk)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence quiet6_s;
      (!pin_chg && async_en) [*6];
   endsequence

   page_miss_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (acc_start && acc_miss) |=> (busy && acc_cnt == RAND_CYC && !page_ok))
      else $error("page miss without random delay");

   page_hit_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (acc_start && !acc_miss) |=> (busy && acc_cnt == PAGE_CYC))
      else $error("page hit without page delay");

   auto_standby_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      quiet6_s |=> O_STANDBY)
      else $error("standby not entered after idle time");

   standby_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (O_STANDBY && !busy) |=> ($stable(O_DQ) && ($stable(O_DQ_OE) || !O_STANDBY)))
      else $error("outputs changed in standby");

   activity_wake_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      pin_chg |=> (!O_STANDBY && idle_cnt == 4'h0))
      else $error("activity did not end standby");

   status_src_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (busy && !acc_start && acc_cnt == 4'h1 && src == SRC_STATUS) |=> (O_DQ == $past(sword)))
      else $error("status source not returned");

   async_wait_a: assert property (@(posedge I_LINK_CLK) disable iff (lrst)
      (!lk.sync_mode) [*2] |=> !O_WAIT)
      else $error("wait asserted in async mode");

endmodule

// File: sim/frbs_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host controller driving the flash pins
// ----------------------------------------
module frbs_host_model #(
   parameter int AW = 8
) (
   // System clock for aligned requests
   input  wire logic          i_sys_clk,
   // Flash pins
   output logic               o_link_clk,
   output logic [AW-1:0]      o_addr,
   output logic               o_adv_n,
   output logic               o_ce_n,
   output logic               o_oe_n
);
   initial
   begin
      o_link_clk = 1'b0;
      o_addr     = '0;
      o_adv_n    = 1'b1;
      o_ce_n     = 1'b1;
      o_oe_n     = 1'b1;
   end

   // One link cycle; the clock stands high between calls.
   task automatic step();
      #62.5 o_link_clk = 1'b0;
      #62.5 o_link_clk = 1'b1;
   endtask

   task automatic idle(input int n);
      repeat (n) step();
   endtask

   // Asynchronous read request.
   task automatic aread(input logic [AW-1:0] a);
      @(posedge i_sys_clk);
      o_addr  <= a;
      o_ce_n  <= 1'b0;
      o_adv_n <= 1'b0;
      o_oe_n  <= 1'b0;
   endtask

   // Synchronous burst: latch, run the clock, deselect.
   task automatic burst(input logic [AW-1:0] a, input int cyc);
      o_ce_n  <= 1'b1;
      o_adv_n <= 1'b1;
      idle(3);
      o_addr  <= a;
      o_ce_n  <= 1'b0;
      o_adv_n <= 1'b0;
      o_oe_n  <= 1'b0;
      step();
      o_adv_n <= 1'b1;
      o_addr  <= ~a;
      idle(cyc);
      o_ce_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      idle(2);
   endtask
endmodule

// File: sim/frbs_top_bench.sv
`timescale 1ns/1ps
`define CHK(name, exp, got) \
   begin checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] %s expected %0h seen %0h", name, exp, got); end end
module frbs_top_bench;
   import frbs_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        link_clk;
   logic [7:0]  addr;
   logic        adv_n;
   logic        ce_n;
   logic        oe_n;
   logic [15:0] dq;
   logic        dq_oe;
   logic        stby;
   logic [15:0] bdq;
   logic        bvalid;
   logic        bwait;
   logic [15:0] mem [0:255];
   logic [15:0] dq_last = 16'h0000;
   logic [32:0] exp_apb [$];
   logic [15:0] exp_dq [$];
   logic [16:0] exp_bst [$];
   logic [32:0] e_apb;
   logic [15:0] e_dq;
   int          miscompares = 0;
   int          checks = 0;
   int          cyc_cnt = 0;

   always #12.5 sys_clk = ~sys_clk;

   frbs_host_model #(.AW(8)) u_host (.i_sys_clk(sys_clk), .o_link_clk(link_clk), .o_addr(addr),
      .o_adv_n(adv_n), .o_ce_n(ce_n), .o_oe_n(oe_n));

   frbs_top #(.AW(8)) u_dut (.I_SYS_CLK(sys_clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_LINK_CLK(link_clk), .I_ADDR(addr), .I_ADV_N(adv_n), .I_CE_N(ce_n),
      .I_OE_N(oe_n), .O_DQ(dq), .O_DQ_OE(dq_oe), .O_STANDBY(stby), .O_BURST_DQ(bdq),
      .O_BURST_VALID(bvalid), .O_WAIT(bwait));

   // ----------------------------------------
   // Closing report and timeout
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      if (pready && psel && penable && !pwrite)
      begin
         e_apb = exp_apb.pop_front();
         `CHK("apb_read", e_apb, {pslverr, prdata})
      end
      cyc_cnt++;
      if (cyc_cnt == 40000)
      begin
         miscompares++;
         stop_test();
      end
   end

   // ----------------------------------------
   // Output monitors
   // ----------------------------------------
   always @(negedge sys_clk)
   begin
      if (!rst && dq !== dq_last)
      begin
         dq_last = dq;
         e_dq = exp_dq.pop_front();
         `CHK("async_dq", e_dq, dq)
      end
   end

   always @(negedge link_clk)
   begin
      logic [16:0] e;
      if (bvalid || bwait)
      begin
         if (exp_bst.size() == 0)
            `CHK("burst_extra", 1'b0, 1'b1)
         else
         begin
            e = exp_bst.pop_front();
            `CHK("burst_wait", e[16], bwait)
            if (!e[16])
               `CHK("burst_data", e[15:0], bdq)
         end
      end
   end

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_apb.push_back(e);
      apb(1'b0, a, 32'h00000000);
   endtask

   task automatic ard(input logic [7:0] a, input logic [15:0] e, output int lat);
      logic [15:0] prev;
      prev = dq;
      exp_dq.push_back(e);
      u_host.aread(a);
      lat = 0;
      while (dq === prev && lat < 30)
      begin
         @(negedge sys_clk);
         lat++;
      end
   endtask

   task automatic exp_burst(input logic [7:0] s, input logic [2:0] ln, input logic wr, output int cyc);
      int n;
      int k;
      int i;
      logic [7:0] a;
      logic lin;
      logic cont;
      logic crossed;
      cont = (ln == LEN_C);
      lin = cont || wr;
      n = (ln == LEN_4) ? 4 : (ln == LEN_8) ? 8 : 16;
      cyc = cont ? 12 : 99;
      k = 0;
      i = 0;
      crossed = 1'b0;
      while (cont ? (k < cyc) : (i < n))
      begin
         a = lin ? s + 8'(i) : ((s & ~8'(n - 1)) | ((s + 8'(i)) & 8'(n - 1)));
         if (lin && i > 0 && a[3:0] == 4'h0 && !crossed)
         begin
            crossed = 1'b1;
            repeat (int'(s[1:0]))
               if (k < cyc)
               begin
                  exp_bst.push_back(17'h10000);
                  k++;
               end
         end
         if (k < cyc)
         begin
            exp_bst.push_back({1'b0, mem[a]});
            k++;
         end
         i++;
      end
      if (!cont)
         cyc = k + 2;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      int lat [0:4];
      int cyc;
      logic [7:0] s;
      logic [2:0] ln;
      logic wr;
      logic [11:0] cases [0:7];
      logic [2:0] lens [0:3];
      logic [15:0] srcw [1:3];
      cases = '{12'h101, 12'h207, 12'h30E, 12'h90D, 12'hA0F, 12'hB03, 12'hB0C, 12'h70E};
      lens = '{LEN_4, LEN_8, LEN_16, LEN_C};
      srcw = '{SWORD_RST, QUERY_WORD, IDENT_WORD};
      void'($urandom(32'h39F3));
      u_host.idle(4);
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      u_host.idle(2);
      rd(OFF_CFG, {1'b0, CFG_RST});
      rd(12'h020, {1'b1, 32'h00000000});
      apb(1'b1, OFF_MADDR, 32'h00000000);
      for (int i = 0; i < 48; i++)
      begin
         mem[i] = {1'b1, 7'($urandom), 8'(i)};
         apb(1'b1, OFF_MDATA, {16'h0000, mem[i]});
      end
      apb(1'b1, OFF_CFG, CFG_RST);
      ard(8'h14, mem[20], lat[0]);
      ard(8'h04, mem[4], lat[0]);
      ard(8'h05, mem[5], lat[1]);
      ard(8'h09, mem[9], lat[2]);
      ard(8'h08, mem[8], lat[3]);
      ard(8'h04, mem[4], lat[4]);
      `CHK("page_gain", lat[0] - lat[1], int'(RAND_CYC - PAGE_CYC))
      `CHK("page_gain2", lat[2] - lat[3], int'(RAND_CYC - PAGE_CYC))
      `CHK("page_change", lat[4], lat[0])
      `CHK("async_oe", dq_oe, 1'b1)
      `CHK("async_wait", bwait, 1'b0)
      repeat (12) @(negedge sys_clk);
      `CHK("standby", stby, 1'b1)
      `CHK("standby_dq", dq, mem[4])
      `CHK("standby_oe", dq_oe, 1'b1)
      rd(OFF_STAT, {1'b0, 32'h0000000B});
      ard(8'h05, mem[5], lat[1]);
      `CHK("standby_exit", stby, 1'b0)
      for (int k = 1; k < 4; k++)
      begin
         apb(1'b1, OFF_CFG, CFG_RST | (32'(k) << CFG_SRC_LSB));
         ard(8'(40 + 4 * k), srcw[k], lat[0]);
      end
      apb(1'b1, OFF_CFG, 32'h0000000F);
      repeat (6) @(negedge sys_clk);
      `CHK("sync_oe", dq_oe, 1'b0)
      for (int j = 0; j < 11; j++)
      begin
         if (j < 8)
            {wr, ln, s} = cases[j];
         else
         begin
            s = 8'($urandom % 32);
            ln = lens[$urandom % 4];
            wr = 1'($urandom);
         end
         apb(1'b1, OFF_CFG, {28'h0000000, wr, ln});
         exp_burst(s, ln, wr, cyc);
         u_host.burst(s, cyc);
         `CHK("burst_left", exp_bst.size(), 0)
         exp_bst.delete();
      end
      stop_test();
   end
endmodule
